//--- hdl/lgtrap_decode.v
`timescale 1ns/1ps
`default_nettype none
`include "lgtrap_map.vh"
// Combinational range decoder: one match line per event number.
module lgtrap_decode
(
	input wire [15:0] addr,
	input wire sb_sel,
	input wire [1:0] base_sel,
	input wire [1:0] cdc_sel,
	output reg [7:0] hit
);
	always @*
	begin
		hit = 8'h00;
		// Base range 320..357 selected in 0x10 steps
		hit[`LGTRAP_EV_BASE] = (addr[15:8] == 8'h03) &&
			(addr[7:4] == (4'h2 + {2'h0, base_sel})) &&
			(addr[3] == 1'b0); // (RULE18) (RULE9)
		// Codec select 01 is undefined and never matches
		case (cdc_sel)
			2'h0: hit[`LGTRAP_EV_CODEC] = (addr[15:3] == 13'h0A6); // (RULE19) (RULE8)
			2'h2: hit[`LGTRAP_EV_CODEC] = (addr[15:3] == 13'h1D0); // (RULE19)
			2'h3: hit[`LGTRAP_EV_CODEC] = (addr[15:3] == 13'h1E8); // (RULE19)
			default: hit[`LGTRAP_EV_CODEC] = 1'b0;
		endcase
		hit[`LGTRAP_EV_GAME] = (addr[15:4] ==
			(sb_sel ? 12'h024 : 12'h022)); // (RULE17) (RULE7)
		hit[`LGTRAP_EV_FM] = (addr[15:2] == 14'h00E2); // (RULE6)
		hit[`LGTRAP_EV_MPIC] = (addr[15:1] == 15'h0010); // (RULE5)
		hit[`LGTRAP_EV_MDMA] = (addr[15:4] == 12'h000); // (RULE4)
		hit[`LGTRAP_EV_SPIC] = (addr[15:1] == 15'h0050); // (RULE3)
		hit[`LGTRAP_EV_SDMA] = (addr[15:5] == 11'h006); // (RULE2)
	end
endmodule
`default_nettype wire

//--- hdl/lgtrap_map.vh
`ifndef LGTRAP_MAP_VH
`define LGTRAP_MAP_VH
// Register byte address within the I/O block
`define LGTRAP_REG_OFFSET 6'h18
// Control field positions
`define LGTRAP_BIT_JFAST 31
`define LGTRAP_BIT_HIB 30
`define LGTRAP_BIT_SBSEL 29
`define LGTRAP_BIT_BASESEL_HI 28
`define LGTRAP_BIT_BASESEL_LO 27
`define LGTRAP_BIT_CDCSEL_HI 26
`define LGTRAP_BIT_CDCSEL_LO 25
`define LGTRAP_BIT_FORCE 24
`define LGTRAP_BIT_EN_HI 23
`define LGTRAP_BIT_EN_LO 16
// Status field positions
`define LGTRAP_BIT_EVNUM_HI 10
`define LGTRAP_BIT_EVNUM_LO 8
`define LGTRAP_BIT_ADDR_HI 7
`define LGTRAP_BIT_ADDR_LO 3
`define LGTRAP_BIT_DIR 2
// Read-as-ones field
`define LGTRAP_ONES 5'h1F
// Reset values
`define LGTRAP_CTRL_RESET 8'h00
`define LGTRAP_EN_RESET 8'h00
// Event numbers
`define LGTRAP_EV_BASE 3'h0
`define LGTRAP_EV_CODEC 3'h1
`define LGTRAP_EV_GAME 3'h2
`define LGTRAP_EV_FM 3'h3
`define LGTRAP_EV_MPIC 3'h4
`define LGTRAP_EV_MDMA 3'h5
`define LGTRAP_EV_SPIC 3'h6
`define LGTRAP_EV_SDMA 3'h7
`endif

//--- hdl/lgtrap_top.v
// Overview of operation
// (RULE1) Force bit 24 drives the legacy interrupt while set.
// (RULE2) Enable bit 23 traps slave DMA range C0-DF.
// (RULE3) Enable bit 22 traps slave interrupt controller range A0-A1.
// (RULE4) Enable bit 21 traps master DMA range 00-0F.
// (RULE5) Enable bit 20 traps master interrupt controller range 20-21.
// (RULE6) Enable bit 19 traps FM synthesizer range 388-38B.
// (RULE7) Enable bit 18 traps the selected game-sound card range.
// (RULE8) Enable bit 17 traps the selected codec range.
// (RULE9) Enable bit 16 traps the selected base-address range.
// (RULE10) Bits 15 to 11 always read as ones.
// (RULE11) Bits 10 to 8 report the captured event source number.
// (RULE12) Event number names the enabled range that hit; every capture interrupts.
// (RULE13) Bits 7 to 3 hold low five address bits of capture.
// (RULE14) Bit 2 shows capture direction: 0 read, 1 write.
// (RULE15) Bit 1 always reads zero.
// (RULE16) Bit 0 reads 0 while pending; any write to it clears.
// (RULE17) Game select 0 picks 220-22F, 1 picks 240-24F.
// (RULE18) Base select picks 320, 330, 340 or 350 through x7.
// (RULE19) Codec select: 530-537, undefined, E80-E87, F40-F47.
// (RULE20) Captured record holds stable until the flag is cleared.
// (RULE21) Host reads event fields before clearing the flag.
`timescale 1ns/1ps
`default_nettype none
`include "lgtrap_map.vh"
module lgtrap_top
(
	input wire clk,
	input wire rst,
	// Register port, in the device's I/O space
	input wire reg_sel,
	input wire reg_wr,
	input wire [5:0] reg_addr,
	input wire [3:0] reg_be,
	input wire [31:0] reg_wdata,
	output reg [31:0] reg_rdata,
	// Snooped host I/O accesses, one cycle pulse per access
	input wire io_valid,
	input wire io_write,
	input wire [15:0] io_addr,
	// Legacy interrupt, active low
	output reg legacy_irq_n
);
	////////////////////////////////////////////////////////////////////
	reg jfast_reg;
	reg host_block_reg;
	reg sb_sel_reg;
	reg [1:0] base_sel_reg;
	reg [1:0] cdc_sel_reg;
	reg force_reg;
	reg [7:0] enable_reg;
	reg pending_reg;
	reg [2:0] trapped_event_number_reg;
	reg [4:0] trap_addr_reg;
	reg trap_dir_reg;
	reg [2:0] ev_next;
	reg ev_found;
	wire [7:0] hit;
	wire [7:0] armed;
	wire reg_hit;
	wire ctl_wr_hi;
	wire ctl_wr_lo;
	wire flag_wr;
	wire [31:0] rd_word;
	integer i;

	lgtrap_decode u_decode
	(
		.addr(io_addr),
		.sb_sel(sb_sel_reg),
		.base_sel(base_sel_reg),
		.cdc_sel(cdc_sel_reg),
		.hit(hit)
	);

	assign armed = hit & enable_reg & {8{io_valid}};
	assign reg_hit = reg_sel && (reg_addr == `LGTRAP_REG_OFFSET);
	assign ctl_wr_hi = reg_hit && reg_wr && reg_be[3];
	assign ctl_wr_lo = reg_hit && reg_wr && reg_be[2];
	assign flag_wr = reg_hit && reg_wr && reg_be[0];

	////////////////////////////////////////////////////////////////////
	// Highest event number wins when two ranges overlap in one access
	always @*
	begin
		ev_next = `LGTRAP_EV_BASE;
		ev_found = 1'b0;
		for (i = 0; i < 8; i = i + 1)
		begin
			if (armed[i])
			begin
				ev_next = i[2:0]; // (RULE12)
				ev_found = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			jfast_reg <= 1'b0;
			host_block_reg <= 1'b0;
			sb_sel_reg <= 1'b0;
			base_sel_reg <= 2'h0;
			cdc_sel_reg <= 2'h0;
			force_reg <= 1'b0;
			enable_reg <= `LGTRAP_EN_RESET;
		end
		else
		begin
			if (ctl_wr_hi)
			begin
				jfast_reg <= reg_wdata[`LGTRAP_BIT_JFAST];
				host_block_reg <= reg_wdata[`LGTRAP_BIT_HIB];
				sb_sel_reg <= reg_wdata[`LGTRAP_BIT_SBSEL];
				base_sel_reg <= reg_wdata[`LGTRAP_BIT_BASESEL_HI:
					`LGTRAP_BIT_BASESEL_LO];
				cdc_sel_reg <= reg_wdata[`LGTRAP_BIT_CDCSEL_HI:
					`LGTRAP_BIT_CDCSEL_LO];
				force_reg <= reg_wdata[`LGTRAP_BIT_FORCE]; // (RULE1)
			end
			if (ctl_wr_lo)
				enable_reg <= reg_wdata[`LGTRAP_BIT_EN_HI:`LGTRAP_BIT_EN_LO];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Capture only while idle so software sees one consistent record;
	// a new hit in the clearing cycle is kept, set wins over clear.
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pending_reg <= 1'b0;
			trapped_event_number_reg <= 3'h0;
			trap_addr_reg <= 5'h00;
			trap_dir_reg <= 1'b0;
		end
		else
		begin
			if (ev_found && (!pending_reg || flag_wr)) // (RULE20)
			begin
				pending_reg <= 1'b1; // (RULE12)
				trapped_event_number_reg <= ev_next; // (RULE11)
				trap_addr_reg <= io_addr[4:0]; // (RULE13)
				trap_dir_reg <= io_write; // (RULE14)
			end
			else if (flag_wr)
				pending_reg <= 1'b0; // (RULE16)
		end
	end

	////////////////////////////////////////////////////////////////////
	assign rd_word = {jfast_reg, host_block_reg, sb_sel_reg, base_sel_reg,
		cdc_sel_reg, force_reg, enable_reg,
		`LGTRAP_ONES, // (RULE10)
		trapped_event_number_reg, trap_addr_reg, trap_dir_reg,
		1'b0, // (RULE15)
		~pending_reg}; // (RULE16)

	// Read data registered; unmapped offsets read zero
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			reg_rdata <= 32'h00000000;
			legacy_irq_n <= 1'b1;
		end
		else
		begin
			reg_rdata <= (reg_hit && !reg_wr) ? rd_word : 32'h00000000;
			legacy_irq_n <= ~(pending_reg | force_reg); // (RULE1)
		end
	end
endmodule
`default_nettype wire

//--- verification/lgtrap_chk.sv
`timescale 1ns/1ps
`default_nettype none
module lgtrap_chk
(
	input wire logic clk,
	input wire logic rst,
	input wire logic reg_sel,
	input wire logic reg_wr,
	input wire logic [5:0] reg_addr,
	input wire logic [3:0] reg_be,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic io_valid,
	input wire logic io_write,
	input wire logic [15:0] io_addr,
	input wire logic legacy_irq_n
);
	logic [7:0] en_reg;
	wire logic wr18 = reg_sel && reg_wr && reg_addr == 6'h18;
	wire logic rd18 = reg_sel && !reg_wr && reg_addr == 6'h18;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	// Shadow of the enables, so hits can be judged from the ports alone
	always @(posedge clk or posedge rst)
		if (rst)
			en_reg <= 8'h00;
		else if (wr18 && reg_be[2])
			en_reg <= reg_wdata[23:16];
	property p_trap(m);
		io_valid && m |-> ##2 !legacy_irq_n;
	endproperty
	// Idle flag and no hit just before, so this hit is the one recorded
	sequence s_fresh;
		legacy_irq_n && !$past(io_valid);
	endsequence
	sequence s_mdma_read;
		io_valid && en_reg[5] && io_addr < 16'h10 ##1 !reg_sel ##1 rd18;
	endsequence
	a_sdma_trap: assert property (p_trap(en_reg[7] && io_addr >= 16'hC0
		&& io_addr <= 16'hDF)) else $error("slave dma hit missed");
	a_spic_trap: assert property (p_trap(en_reg[6] && io_addr[15:1] == 15'h50))
		else $error("slave pic hit missed");
	a_mdma_trap: assert property (p_trap(en_reg[5] && io_addr < 16'h10))
		else $error("master dma hit missed");
	a_mpic_trap: assert property (p_trap(en_reg[4] && io_addr[15:1] == 15'h10))
		else $error("master pic hit missed");
	a_fm_trap: assert property (p_trap(en_reg[3] && io_addr[15:2] == 14'hE2))
		else $error("fm hit missed");
	a_force_low: assert property (wr18 && reg_be[3] && reg_wdata[24]
		|-> ##2 !legacy_irq_n) else $error("force did not interrupt");
	a_clear_high: assert property (wr18 && reg_be[0] && reg_be[3]
		&& !reg_wdata[24] && !io_valid ##1 !io_valid |-> ##1 legacy_irq_n)
		else $error("clear failed");
	a_read_fixed: assert property (rd18 |=> reg_rdata[15:11] == 5'h1F
		&& !reg_rdata[1]) else $error("fixed bits wrong");
	a_record_fields: assert property (s_fresh ##0 s_mdma_read |=> reg_rdata[10:0]
		== {3'h5, $past(io_addr[4:0], 3), $past(io_write, 3), 2'h0}) else $error("record wrong");
endmodule
bind lgtrap_top lgtrap_chk i_chk (.clk(clk), .rst(rst), .reg_sel(reg_sel),
	.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_be(reg_be), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .io_valid(io_valid), .io_write(io_write),
	.io_addr(io_addr), .legacy_irq_n(legacy_irq_n));
`default_nettype wire

//--- verification/lgtrap_host.sv
`timescale 1ns/1ps
`default_nettype none
module lgtrap_host
(
	input wire logic clk,
	output logic io_valid,
	output logic io_write,
	output logic [15:0] io_addr
);
	initial
		{io_valid, io_write, io_addr} = {2'h0, 16'hFFFF};
	task automatic access(input logic w, input logic [15:0] a);
		@(posedge clk);
		{io_valid, io_write, io_addr} <= {1'h1, w, a};
		@(posedge clk);
		// Released lines flip, so a stale address never passes for a live one
		{io_valid, io_write, io_addr} <= {1'h0, ~w, ~a};
	endtask
endmodule
`default_nettype wire

//--- verification/lgtrap_tb.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk, rst, reg_sel, reg_wr, io_valid, io_write, legacy_irq_n;
	logic [5:0] reg_addr;
	logic [3:0] reg_be;
	logic [31:0] reg_wdata, reg_rdata, rd;
	logic [15:0] io_addr;
	int fails = 0, num_checks = 0, cycles = 0;
	logic [31:0] tab [14] = '{32'h000700DF, 32'h000600A1, 32'h0005000F,
		32'h00040020, 32'h0003038B, 32'h0002022F, 32'h20020240,
		32'h00010537, 32'h04010E80, 32'h06010F47, 32'h00000320,
		32'h08000337, 32'h10000345, 32'h18000357};
	lgtrap_top i_lgtrap_top (.clk(clk), .rst(rst), .reg_sel(reg_sel),
		.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_be(reg_be),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .io_valid(io_valid),
		.io_write(io_write), .io_addr(io_addr), .legacy_irq_n(legacy_irq_n));
	lgtrap_host i_host (.clk(clk), .io_valid(io_valid), .io_write(io_write),
		.io_addr(io_addr));
	initial
	begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			fails++;
			conclude();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("checks=%0d fails=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic nap(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic acc(input logic w, input logic [5:0] ad, input logic [3:0] be,
		input logic [31:0] d);
		@(posedge clk);
		{reg_sel, reg_wr, reg_addr, reg_be, reg_wdata} <= {1'h1, w, ad, be, d};
		@(posedge clk);
		{reg_sel, reg_wdata} <= {1'h0, ~d};
		#1 rd = reg_rdata;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		acc(1'h0, 6'h18, 4'h0, 32'h0);
		cmp({rd[31:11], rd[1:0], legacy_irq_n}, 32'hFB);
	endtask
	task automatic t_force();
		acc(1'h1, 6'h18, 4'h8, 32'hC1000000);
		nap(1);
		cmp(legacy_irq_n, 32'h0);
		acc(1'h1, 6'h18, 4'h2, 32'hFFFFFFFF);
		acc(1'h0, 6'h18, 4'h0, 32'h0);
		cmp({rd[31:24], rd[15:11], rd[1]}, 32'h307E);
		acc(1'h1, 6'h18, 4'h8, 32'h0);
		nap(1);
		cmp(legacy_irq_n, 32'h1);
		acc(1'h0, 6'h1C, 4'h0, 32'h0);
		cmp(rd, 32'h0);
	endtask
	task automatic t_trap(input logic [31:0] e, input logic w);
		logic [7:0] m;
		m = 8'h01 << e[18:16];
		acc(1'h1, 6'h18, 4'hC, {e[31:24], ~m, 16'h0});
		i_host.access(w, e[15:0]);
		nap(2);
		cmp(legacy_irq_n, 32'h1);
		acc(1'h1, 6'h18, 4'h4, {8'h0, m, 16'h0});
		i_host.access(w, e[15:0]);
		acc(1'h0, 6'h18, 4'h0, 32'h0);
		cmp(rd[10:0], {e[18:16], e[4:0], w, 2'h0});
		cmp({legacy_irq_n, rd[0]}, 32'h0);
		i_host.access(~w, e[15:0] ^ 16'h1);
		acc(1'h0, 6'h18, 4'h0, 32'h0);
		cmp(rd[10:0], {e[18:16], e[4:0], w, 2'h0});
		acc(1'h1, 6'h18, 4'h9, {e[31:24], 24'h0});
		nap(2);
		cmp(legacy_irq_n, 32'h1);
	endtask
	initial
	begin
		{rst, reg_sel, reg_wr, reg_addr, reg_be, reg_wdata} = {1'h1, 44'h0};
		repeat (5) @(posedge clk);
		rst <= 1'h0;
		t_reset();
		t_force();
		foreach (tab[i])
			t_trap(tab[i], i[0]);
		conclude();
	end
endmodule
`default_nettype wire
